//--- rtl/csr_pkg.sv
// constants and types shared by the configurable shift register
package csr_pkg;

    // ********************************************************************
    // widths
    // ********************************************************************
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    localparam int WORD_WIDTH = 8;

    // ********************************************************************
    // register byte offsets
    // ********************************************************************
    localparam logic [7:0] OFS_CTRL         = 8'h00;
    localparam logic [7:0] OFS_POWER_UP     = 8'h04;
    localparam logic [7:0] OFS_SYNC_CLEAR   = 8'h08;
    localparam logic [7:0] OFS_SYNC_PRESET  = 8'h0C;
    localparam logic [7:0] OFS_ASYNC_CLEAR  = 8'h10;
    localparam logic [7:0] OFS_ASYNC_PRESET = 8'h14;
    localparam logic [7:0] OFS_STATUS       = 8'h18;

    // ********************************************************************
    // field positions
    // ********************************************************************
    localparam int CTRL_EDGE_BIT     = 0;
    localparam int CTRL_DIR_POL_BIT  = 1;
    localparam int CTRL_LOAD_POL_BIT = 2;
    localparam int CTRL_SR_POL_BIT   = 3;
    localparam int CTRL_VARIANT_LSB  = 4;
    localparam int CTRL_RESTART_BIT  = 8;
    localparam int STATUS_CLK_BIT    = 8;

    // ********************************************************************
    // variants
    // ********************************************************************
    typedef enum logic [1:0] {
        VARIANT_BIDIR = 2'b00,
        VARIANT_LEFT  = 2'b01,
        VARIANT_RIGHT = 2'b10
    } csr_variant_type;

    // ********************************************************************
    // reset values
    // ********************************************************************
    localparam logic            RST_EDGE_FALL    = 1'h0;
    localparam logic            RST_DIR_POL      = 1'h1;
    localparam logic            RST_LOAD_POL     = 1'h1;
    localparam logic            RST_SR_POL       = 1'h1;
    localparam csr_variant_type RST_VARIANT      = VARIANT_BIDIR;
    localparam logic [7:0]      RST_POWER_UP     = 8'h00;
    localparam logic [7:0]      RST_SYNC_CLEAR   = 8'h00;
    localparam logic [7:0]      RST_SYNC_PRESET  = 8'hFF;
    localparam logic [7:0]      RST_ASYNC_CLEAR  = 8'h00;
    localparam logic [7:0]      RST_ASYNC_PRESET = 8'hFF;

    // ********************************************************************
    // bus responses
    // ********************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : csr_pkg

//--- rtl/csr_shift_register.sv
// configurable shift register with an axi4-lite configuration slave
//
// Function
// - word loads, shifts and takes sync values only on the selected shift clock edge, rising or falling
// - bidirectional: direction polarity 1 means high shifts left, 0 inverts
// - load polarity 1 means high loads, low shifts; 0 inverts
// - set and reset pins active high at polarity 1, active low at 0
// - async clear or preset pins force their values without a shift edge
// - sync clear or preset pins force their values on the shift edge
// - word holds the power-up value until first load, shift, set or reset
// - parallel input and output words are word_width bits wide
`timescale 1ns/1ps
`default_nettype none

module csr_shift_register (
    // system
    input  wire logic                            clock,
    input  wire logic                            rstn,
    // axi4-lite write address and data
    input  wire logic [csr_pkg::ADDR_WIDTH-1:0]  awaddr,
    input  wire logic                            awvalid,
    output logic                                 awready,
    input  wire logic [csr_pkg::DATA_WIDTH-1:0]  wdata,
    input  wire logic [3:0]                      wstrb,
    input  wire logic                            wvalid,
    output logic                                 wready,
    // axi4-lite write response
    output logic [1:0]                           bresp,
    output logic                                 bvalid,
    input  wire logic                            bready,
    // axi4-lite read
    input  wire logic [csr_pkg::ADDR_WIDTH-1:0]  araddr,
    input  wire logic                            arvalid,
    output logic                                 arready,
    output logic [csr_pkg::DATA_WIDTH-1:0]       rdata,
    output logic [1:0]                           rresp,
    output logic                                 rvalid,
    input  wire logic                            rready,
    // shift register pins
    input  wire logic                            shiftClock,
    input  wire logic                            direction,
    input  wire logic                            loadShift,
    input  wire logic                            serialIn,
    input  wire logic [csr_pkg::WORD_WIDTH-1:0]  parallelIn,
    input  wire logic                            syncClearPin,
    input  wire logic                            syncPresetPin,
    input  wire logic                            asyncClearPin,
    input  wire logic                            asyncPresetPin,
    // shift register outputs
    output logic [csr_pkg::WORD_WIDTH-1:0]       parallelOut,
    output logic                                 serialOutLeft,
    output logic                                 serialOutRight
);

    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        logic                            edgeFall;
        logic                            dirPol;
        logic                            loadPol;
        logic                            srPol;
        csr_pkg::csr_variant_type        variant;
        logic [csr_pkg::WORD_WIDTH-1:0]  powerUp;
        logic [csr_pkg::WORD_WIDTH-1:0]  syncClear;
        logic [csr_pkg::WORD_WIDTH-1:0]  syncPreset;
        logic [csr_pkg::WORD_WIDTH-1:0]  asyncClear;
        logic [csr_pkg::WORD_WIDTH-1:0]  asyncPreset;
        logic [csr_pkg::WORD_WIDTH-1:0]  word;
        logic                            shiftClkPrev;
        logic                            awHeld;
        logic [csr_pkg::ADDR_WIDTH-1:0]  awAddr;
        logic                            wHeld;
        logic [csr_pkg::DATA_WIDTH-1:0]  wData;
        logic [3:0]                      wStrb;
        logic                            awready;
        logic                            wready;
        logic                            bvalid;
        logic [1:0]                      bresp;
        logic                            arready;
        logic                            rvalid;
        logic [1:0]                      rresp;
        logic [csr_pkg::DATA_WIDTH-1:0]  rdata;
    } csr_state_type;

    // ********************************************************************
    // functions
    // ********************************************************************
    function automatic csr_state_type resetState();
        csr_state_type s;
        s             = '0;
        s.edgeFall    = csr_pkg::RST_EDGE_FALL;
        s.dirPol      = csr_pkg::RST_DIR_POL;
        s.loadPol     = csr_pkg::RST_LOAD_POL;
        s.srPol       = csr_pkg::RST_SR_POL;
        s.variant     = csr_pkg::RST_VARIANT;
        s.powerUp     = csr_pkg::RST_POWER_UP;
        s.syncClear   = csr_pkg::RST_SYNC_CLEAR;
        s.syncPreset  = csr_pkg::RST_SYNC_PRESET;
        s.asyncClear  = csr_pkg::RST_ASYNC_CLEAR;
        s.asyncPreset = csr_pkg::RST_ASYNC_PRESET;
        s.word        = csr_pkg::RST_POWER_UP;
        s.bresp       = csr_pkg::RESP_OKAY;
        s.rresp       = csr_pkg::RESP_OKAY;
        return s;
    endfunction : resetState

    function automatic logic isMapped(input logic [csr_pkg::ADDR_WIDTH-1:0] a);
        return (a == csr_pkg::OFS_CTRL) || (a == csr_pkg::OFS_POWER_UP)
            || (a == csr_pkg::OFS_SYNC_CLEAR) || (a == csr_pkg::OFS_SYNC_PRESET)
            || (a == csr_pkg::OFS_ASYNC_CLEAR) || (a == csr_pkg::OFS_ASYNC_PRESET)
            || (a == csr_pkg::OFS_STATUS);
    endfunction : isMapped

    // restart bit always reads as zero
    function automatic logic [31:0] regValue(input csr_state_type s,
                                             input logic [csr_pkg::ADDR_WIDTH-1:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == csr_pkg::OFS_CTRL) begin
            v[csr_pkg::CTRL_EDGE_BIT]     = s.edgeFall;
            v[csr_pkg::CTRL_DIR_POL_BIT]  = s.dirPol;
            v[csr_pkg::CTRL_LOAD_POL_BIT] = s.loadPol;
            v[csr_pkg::CTRL_SR_POL_BIT]   = s.srPol;
            v[csr_pkg::CTRL_VARIANT_LSB +: 2] = s.variant;
        end else if (a == csr_pkg::OFS_POWER_UP) begin
            v[csr_pkg::WORD_WIDTH-1:0] = s.powerUp;
        end else if (a == csr_pkg::OFS_SYNC_CLEAR) begin
            v[csr_pkg::WORD_WIDTH-1:0] = s.syncClear;
        end else if (a == csr_pkg::OFS_SYNC_PRESET) begin
            v[csr_pkg::WORD_WIDTH-1:0] = s.syncPreset;
        end else if (a == csr_pkg::OFS_ASYNC_CLEAR) begin
            v[csr_pkg::WORD_WIDTH-1:0] = s.asyncClear;
        end else if (a == csr_pkg::OFS_ASYNC_PRESET) begin
            v[csr_pkg::WORD_WIDTH-1:0] = s.asyncPreset;
        end else if (a == csr_pkg::OFS_STATUS) begin
            v[csr_pkg::WORD_WIDTH-1:0]    = s.word;
            v[csr_pkg::STATUS_CLK_BIT]    = s.shiftClkPrev;
        end
        return v;
    endfunction : regValue

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] neu,
                                               input logic [3:0]  strb);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[i*8 +: 8] = neu[i*8 +: 8];
            end
        end
        return v;
    endfunction : mergeBytes

    localparam csr_state_type STATE_RESET = resetState();

    csr_state_type st_r;
    csr_state_type st_nxt;

    // ********************************************************************
    // next state
    // ********************************************************************
    always_comb begin
        logic        restart;
        logic        clkEdge;
        logic        shiftLeft;
        logic [31:0] merged;
        restart   = 1'h0;
        clkEdge   = 1'h0;
        shiftLeft = 1'h0;
        merged    = 32'h0000_0000;
        st_nxt    = st_r;

        // write address and data are taken in either order
        if (awvalid && st_r.awready) begin
            st_nxt.awHeld = 1'h1;
            st_nxt.awAddr = awaddr;
        end
        if (wvalid && st_r.wready) begin
            st_nxt.wHeld = 1'h1;
            st_nxt.wData = wdata;
            st_nxt.wStrb = wstrb;
        end
        if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'h0;
        end
        if (st_r.awHeld && st_r.wHeld && !st_r.bvalid) begin
            st_nxt.awHeld = 1'h0;
            st_nxt.wHeld  = 1'h0;
            st_nxt.bvalid = 1'h1;
            st_nxt.bresp  = csr_pkg::RESP_OKAY;
            merged = mergeBytes(regValue(st_r, st_r.awAddr), st_r.wData, st_r.wStrb);
            if (st_r.awAddr == csr_pkg::OFS_CTRL) begin
                st_nxt.edgeFall = merged[csr_pkg::CTRL_EDGE_BIT];
                st_nxt.dirPol   = merged[csr_pkg::CTRL_DIR_POL_BIT];
                st_nxt.loadPol  = merged[csr_pkg::CTRL_LOAD_POL_BIT];
                st_nxt.srPol    = merged[csr_pkg::CTRL_SR_POL_BIT];
                st_nxt.variant  =
                    csr_pkg::csr_variant_type'(merged[csr_pkg::CTRL_VARIANT_LSB +: 2]);
                restart = merged[csr_pkg::CTRL_RESTART_BIT];
            end else if (st_r.awAddr == csr_pkg::OFS_POWER_UP) begin
                st_nxt.powerUp = merged[csr_pkg::WORD_WIDTH-1:0];
            end else if (st_r.awAddr == csr_pkg::OFS_SYNC_CLEAR) begin
                st_nxt.syncClear = merged[csr_pkg::WORD_WIDTH-1:0];
            end else if (st_r.awAddr == csr_pkg::OFS_SYNC_PRESET) begin
                st_nxt.syncPreset = merged[csr_pkg::WORD_WIDTH-1:0];
            end else if (st_r.awAddr == csr_pkg::OFS_ASYNC_CLEAR) begin
                st_nxt.asyncClear = merged[csr_pkg::WORD_WIDTH-1:0];
            end else if (st_r.awAddr == csr_pkg::OFS_ASYNC_PRESET) begin
                st_nxt.asyncPreset = merged[csr_pkg::WORD_WIDTH-1:0];
            end else if (!isMapped(st_r.awAddr)) begin
                st_nxt.bresp = csr_pkg::RESP_SLVERR;
            end
        end
        // one write in flight: no new address or data until the response is taken
        st_nxt.awready = !st_nxt.awHeld && !st_nxt.bvalid;
        st_nxt.wready  = !st_nxt.wHeld && !st_nxt.bvalid;

        // read channel
        if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'h0;
        end
        if (arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'h1;
            st_nxt.rdata  = regValue(st_r, araddr);
            st_nxt.rresp  = isMapped(araddr) ? csr_pkg::RESP_OKAY : csr_pkg::RESP_SLVERR;
        end
        st_nxt.arready = !st_nxt.rvalid;

        // shift clock is a sampled pin; its selected edge becomes an enable
        st_nxt.shiftClkPrev = shiftClock;
        if (st_r.edgeFall) begin
            clkEdge = st_r.shiftClkPrev && !shiftClock;
        end else begin
            clkEdge = !st_r.shiftClkPrev && shiftClock;
        end
        shiftLeft = (direction == st_r.dirPol);

        // async pins act in the next cycle whatever the shift clock does
        if (asyncClearPin == st_r.srPol) begin
            st_nxt.word = st_r.asyncClear;
        end else if (asyncPresetPin == st_r.srPol) begin
            st_nxt.word = st_r.asyncPreset;
        end else if (restart) begin
            st_nxt.word = st_r.powerUp;
        end else if (clkEdge) begin
            if (syncClearPin == st_r.srPol) begin
                st_nxt.word = st_r.syncClear;
            end else if (syncPresetPin == st_r.srPol) begin
                st_nxt.word = st_r.syncPreset;
            end else if (loadShift == st_r.loadPol) begin
                st_nxt.word = parallelIn;
            end else begin
                case (st_r.variant)
                    csr_pkg::VARIANT_LEFT: begin
                        st_nxt.word = {st_r.word[csr_pkg::WORD_WIDTH-2:0], serialIn};
                    end
                    csr_pkg::VARIANT_RIGHT: begin
                        st_nxt.word = {serialIn, st_r.word[csr_pkg::WORD_WIDTH-1:1]};
                    end
                    default: begin
                        if (shiftLeft) begin
                            st_nxt.word = {st_r.word[csr_pkg::WORD_WIDTH-2:0], serialIn};
                        end else begin
                            st_nxt.word = {serialIn, st_r.word[csr_pkg::WORD_WIDTH-1:1]};
                        end
                    end
                endcase
            end
        end
    end

    // ********************************************************************
    // registers
    // ********************************************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r <= STATE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    assign awready        = st_r.awready;
    assign wready         = st_r.wready;
    assign bvalid         = st_r.bvalid;
    assign bresp          = st_r.bresp;
    assign arready        = st_r.arready;
    assign rvalid         = st_r.rvalid;
    assign rresp          = st_r.rresp;
    assign rdata          = st_r.rdata;
    assign parallelOut    = st_r.word;
    assign serialOutLeft  = st_r.word[csr_pkg::WORD_WIDTH-1];
    assign serialOutRight = st_r.word[0];

endmodule : csr_shift_register

`default_nettype wire

//--- sim/csr_pin_driver.sv
// model of the surrounding logic that pulses the shift clock
`timescale 1ns/1ps
`default_nettype none
module csr_pin_driver (
    // system
    input  wire logic clock,
    input  wire logic rstn,
    // request
    input  wire logic stepReq,
    // pin
    output logic      shiftClock
);
    // high two cycles, low six: each level outlasts one sample
    logic [2:0] phase_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase_r <= 3'h0;
        end else if (phase_r != 3'h0) begin
            phase_r <= phase_r + 3'h1;
        end else if (stepReq) begin
            phase_r <= 3'h1;
        end
    end
    assign shiftClock = phase_r == 3'h1 || phase_r == 3'h2;
endmodule : csr_pin_driver
`default_nettype wire

//--- sim/csr_shift_register_asserts.sv
// concurrent checks on the shift register pins
`timescale 1ns/1ps
`default_nettype none
module csr_shift_register_asserts (
    // system
    input wire logic                           clock,
    input wire logic                           rstn,
    // register writes
    input wire logic [csr_pkg::ADDR_WIDTH-1:0] awaddr,
    input wire logic                           awvalid,
    input wire logic                           awready,
    input wire logic [csr_pkg::DATA_WIDTH-1:0] wdata,
    input wire logic [3:0]                     wstrb,
    input wire logic                           wvalid,
    input wire logic                           wready,
    // pins
    input wire logic                           shiftClock,
    input wire logic                           direction,
    input wire logic                           loadShift,
    input wire logic                           serialIn,
    input wire logic [csr_pkg::WORD_WIDTH-1:0] parallelIn,
    input wire logic                           syncClearPin,
    input wire logic                           syncPresetPin,
    input wire logic                           asyncClearPin,
    input wire logic                           asyncPresetPin,
    input wire logic [csr_pkg::WORD_WIDTH-1:0] parallelOut,
    input wire logic                           serialOutLeft,
    input wire logic                           serialOutRight
);
    // shadow of the low bytes; checks pause while a write settles
    logic [7:0] cfg_r [6];
    logic       clkPrev_r;
    logic [1:0] wrCnt_r;
    wire take  = awvalid && awready && wvalid && wready && awaddr < 8'h18 && awaddr[1:0] == 2'h0;
    wire pol   = cfg_r[0][3];
    wire aClr  = asyncClearPin == pol;
    wire aPre  = asyncPresetPin == pol;
    wire sClr  = syncClearPin == pol;
    wire sPre  = syncPresetPin == pol;
    wire hit   = cfg_r[0][0] ? (clkPrev_r && !shiftClock) : (!clkPrev_r && shiftClock);
    wire quiet = wrCnt_r == 2'h0;
    wire left  = cfg_r[0][5:4] == 2'h1 || (cfg_r[0][5:4] != 2'h2 && direction == cfg_r[0][1]);
    wire [7:0] shifted = left ? {parallelOut[6:0], serialIn} : {serialIn, parallelOut[7:1]};
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg_r     <= '{8'h0E, csr_pkg::RST_POWER_UP, csr_pkg::RST_SYNC_CLEAR,
                           csr_pkg::RST_SYNC_PRESET, csr_pkg::RST_ASYNC_CLEAR,
                           csr_pkg::RST_ASYNC_PRESET};
            clkPrev_r <= 1'b0;
            wrCnt_r   <= 2'h0;
        end else begin
            clkPrev_r <= shiftClock;
            wrCnt_r   <= (awvalid && awready) ? 2'h3 : (quiet ? 2'h0 : wrCnt_r - 2'h1);
            if (take && wstrb[0]) begin
                cfg_r[awaddr[4:2]] <= wdata[7:0];
            end
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_clean_edge;
        quiet && hit && !aClr && !aPre;
    endsequence
    a_edge_gate: assert property ($changed(parallelOut) |-> $past(hit || aClr || aPre || !quiet))
        else $error("word moved without a selected edge");
    a_async_clear: assert property (quiet && aClr |=> parallelOut == cfg_r[4])
        else $error("async clear value not taken");
    a_async_preset: assert property (quiet && aPre && !aClr |=> parallelOut == cfg_r[5])
        else $error("async preset value not taken");
    a_sync_clear: assert property (s_clean_edge ##0 sClr |=> parallelOut == cfg_r[2])
        else $error("sync clear value not taken");
    a_sync_preset: assert property (s_clean_edge ##0 (sPre && !sClr) |=> parallelOut == cfg_r[3])
        else $error("sync preset value not taken");
    a_load_word: assert property (s_clean_edge ##0 (!sClr && !sPre && loadShift == cfg_r[0][2])
        |=> parallelOut == $past(parallelIn))
        else $error("parallel load wrong");
    a_shift_word: assert property (s_clean_edge ##0 (!sClr && !sPre && loadShift != cfg_r[0][2])
        |=> parallelOut == $past(shifted))
        else $error("shift result wrong");
    a_serial_taps: assert property (serialOutLeft == parallelOut[7] && serialOutRight == parallelOut[0])
        else $error("serial outputs do not follow word ends");
endmodule : csr_shift_register_asserts
bind csr_shift_register csr_shift_register_asserts u_asserts (
    .clock(clock), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .shiftClock(shiftClock),
    .direction(direction), .loadShift(loadShift), .serialIn(serialIn), .parallelIn(parallelIn),
    .syncClearPin(syncClearPin), .syncPresetPin(syncPresetPin), .asyncClearPin(asyncClearPin),
    .asyncPresetPin(asyncPresetPin), .parallelOut(parallelOut), .serialOutLeft(serialOutLeft),
    .serialOutRight(serialOutRight));
`default_nettype wire

//--- sim/csr_shift_register_tb.sv
// self-checking bench for the configurable shift register
`timescale 1ns/1ps
`default_nettype none
module csr_shift_register_tb;
    localparam logic [1:0] OK = csr_pkg::RESP_OKAY;
    localparam logic [7:0] CT = csr_pkg::OFS_CTRL;
    logic        clock, rstn, awvalid, wvalid, bready, arvalid, rready, stepReq, shiftClock;
    logic        direction, loadShift, serialIn, edgeFall;
    logic        syncClearPin, syncPresetPin, asyncClearPin, asyncPresetPin;
    logic        awready, wready, bvalid, arready, rvalid, serialOutLeft, serialOutRight;
    logic [7:0]  awaddr, araddr, parallelIn, parallelOut;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          num_errors = 0;
    int          checks = 0;
    csr_shift_register dut (.clock(clock), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .shiftClock(shiftClock), .direction(direction), .loadShift(loadShift),
        .serialIn(serialIn), .parallelIn(parallelIn), .syncClearPin(syncClearPin),
        .syncPresetPin(syncPresetPin), .asyncClearPin(asyncClearPin),
        .asyncPresetPin(asyncPresetPin), .parallelOut(parallelOut),
        .serialOutLeft(serialOutLeft), .serialOutRight(serialOutRight));
    csr_pin_driver u_pins (.clock(clock), .rstn(rstn), .stepReq(stepReq), .shiftClock(shiftClock));
    // ********
    // tasks
    // ********
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic guard(input int n);
        if (n > 50) begin
            num_errors++;
            wrap_up();
        end
    endtask : guard
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n == 0 || awvalid || wvalid || bready; n++) begin
            @(posedge clock);
            guard(n);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                check("bresp", 32'(bresp), 32'(er));
                bready <= 1'b0;
            end
        end
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n == 0 || arvalid || rready; n++) begin
            @(posedge clock);
            guard(n);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                check("rdata", rdata, ed);
                check("rresp", 32'(rresp), 32'(er));
                rready <= 1'b0;
            end
        end
    endtask : axi_read
    // one shift clock pulse; early look tells rising from falling action
    task automatic shift_op(input logic ld, dr, si, input logic [7:0] pi, ex);
        logic [7:0] old;
        old = parallelOut;
        loadShift <= ld;
        direction <= dr;
        serialIn <= si;
        parallelIn <= pi;
        @(posedge clock);
        stepReq <= 1'b1;
        @(posedge clock);
        stepReq <= 1'b0;
        repeat (2) @(posedge clock);
        check("early word", 32'(parallelOut), 32'(edgeFall ? old : ex));
        repeat (6) @(posedge clock);
        check("word", 32'(parallelOut), 32'(ex));
    endtask : shift_op
    task automatic pins(input logic v);
        syncClearPin <= v;
        syncPresetPin <= v;
        asyncClearPin <= v;
        asyncPresetPin <= v;
    endtask : pins
    // ********
    // sequence
    // ********
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        {rstn, awvalid, wvalid, bready, arvalid, rready, stepReq, direction} = '0;
        {loadShift, serialIn, edgeFall, awaddr, araddr, parallelIn, wdata, wstrb} = '0;
        {syncClearPin, syncPresetPin, asyncClearPin, asyncPresetPin} = '0;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        check("power up", 32'(parallelOut), 32'h0);
        axi_read(CT, 32'h0E, OK);
        axi_read(8'h1C, 32'h0, csr_pkg::RESP_SLVERR);
        axi_write(8'h1C, 32'h5, csr_pkg::RESP_SLVERR);
        shift_op(1, 0, 0, 8'hA5, 8'hA5);
        shift_op(0, 1, 1, 8'h00, 8'h4B);
        shift_op(0, 0, 0, 8'h00, 8'h25);
        axi_write(CT, 32'h0C, OK);
        shift_op(0, 1, 1, 8'h00, 8'h92);
        axi_write(CT, 32'h08, OK);
        shift_op(0, 0, 0, 8'h3C, 8'h3C);
        shift_op(1, 0, 1, 8'h00, 8'h79);
        axi_write(CT, 32'h1E, OK);
        shift_op(0, 0, 1, 8'h00, 8'hF3);
        axi_write(CT, 32'h2E, OK);
        shift_op(0, 1, 0, 8'h00, 8'h79);
        axi_write(CT, 32'h0F, OK);
        edgeFall = 1'b1;
        shift_op(1, 0, 0, 8'h5A, 8'h5A);
        edgeFall = 1'b0;
        axi_write(CT, 32'h0E, OK);
        axi_write(csr_pkg::OFS_SYNC_CLEAR, 32'h81, OK);
        axi_write(csr_pkg::OFS_SYNC_PRESET, 32'h7E, OK);
        syncClearPin <= 1'b1;
        shift_op(1, 0, 0, 8'h33, 8'h81);
        syncClearPin <= 1'b0;
        syncPresetPin <= 1'b1;
        shift_op(1, 0, 0, 8'h33, 8'h7E);
        syncClearPin <= 1'b1;
        shift_op(0, 0, 0, 8'h33, 8'h81);
        pins(1'b0);
        axi_write(csr_pkg::OFS_ASYNC_CLEAR, 32'h42, OK);
        axi_write(csr_pkg::OFS_ASYNC_PRESET, 32'h24, OK);
        asyncPresetPin <= 1'b1;
        repeat (3) @(posedge clock);
        check("async preset", 32'(parallelOut), 32'h24);
        asyncClearPin <= 1'b1;
        shift_op(1, 0, 0, 8'h11, 8'h42);
        pins(1'b0);
        shift_op(1, 0, 0, 8'h11, 8'h11);
        axi_write(CT, 32'h06, OK);
        repeat (3) @(posedge clock);
        check("low clear", 32'(parallelOut), 32'h42);
        pins(1'b1);
        shift_op(1, 0, 0, 8'h66, 8'h66);
        axi_write(CT, 32'h0E, OK);
        pins(1'b0);
        axi_write(csr_pkg::OFS_POWER_UP, 32'h99, OK);
        axi_read(csr_pkg::OFS_POWER_UP, 32'h99, OK);
        axi_write(CT, 32'h10E, OK);
        repeat (2) @(posedge clock);
        check("restart", 32'(parallelOut), 32'h99);
        axi_read(csr_pkg::OFS_STATUS, 32'h99, OK);
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        check("second reset", 32'(parallelOut), 32'h0);
        rstn <= 1'b1;
        @(posedge clock);
        axi_read(CT, 32'h0E, OK);
        wrap_up();
    end
endmodule : csr_shift_register_tb
`default_nettype wire
